/* File: hw/exc_seq_pkg.sv */
// Package for the exception sequencer: register map, vectors and types.
// Assumes a single 100 MHz system clock domain and a 32-bit core datapath.
package exc_seq_pkg;

  // ---------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] EVT_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] EVT_MASK_OFFSET   = 8'h04;
  localparam logic [7:0] LAST_EXC_OFFSET   = 8'h08;
  localparam logic [4:0] EVT_MASK_RESET    = 5'h00;
  localparam int         EVT_WIDTH         = 5;
  // Event bit positions
  localparam int EVT_POR_BIT  = 0;
  localparam int EVT_MRST_BIT = 1;
  localparam int EVT_AERR_BIT = 2;
  localparam int EVT_INT_BIT  = 3;
  localparam int EVT_INSN_BIT = 4;

  // ---------------------------------------------------------------
  // Vector numbers and fixed levels
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_POR_PC     = 8'h00;
  localparam logic [7:0] VEC_MRST_PC    = 8'h02;
  localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL   = 8'h06;
  localparam logic [7:0] VEC_CPU_AERR   = 8'h09;
  localparam logic [7:0] VEC_XFER_AERR  = 8'h0A;
  localparam logic [7:0] VEC_NMI        = 8'h0B;
  localparam logic [7:0] VEC_USER_BREAK = 8'h0C;
  localparam logic [3:0] NMI_LEVEL      = 4'hF;
  localparam logic [3:0] BREAK_LEVEL    = 4'hF;
  localparam logic [3:0] MASK_ON_RESET  = 4'hF;
  localparam logic [31:0] VBR_ON_RESET  = 32'h0000_0000;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  localparam int          MASK_LSB      = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_OTHER, OP_UNDEFINED, OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB,
    OP_RETURN, OP_EXC_RETURN, OP_DBR_FALSE, OP_DBR_TRUE, OP_FAR_BRANCH,
    OP_FAR_BRANCH_SUB, OP_BR_TRUE, OP_BR_FALSE, OP_TRAP
  } op_class_type;

  typedef enum {
    ST_IDLE, ST_RST_PC, ST_RST_SP, ST_WAIT_DONE, ST_PUSH_SR, ST_PUSH_PC, ST_FETCH_VEC
  } seq_state_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic        pc_load;
    logic        sp_load;
    logic        sr_load;
    logic        vbr_load;
    logic [31:0] pc_value;
    logic [31:0] sp_value;
    logic [31:0] sr_value;
    logic [31:0] vbr_value;
  } core_load_type;

endpackage

/* File: hw/cpu_exception_sequencer.sv */
// Exception sequencer: arbitration, reset entry and general entry.
// Assumes decoder, interrupt controller and memory port on pclk; reset
// pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
module cpu_exception_sequencer
  import exc_seq_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  // Reset pins (asynchronous)
  input  wire logic          power_on_reset_pin,
  input  wire logic          manual_reset_pin,
  // Decoder and pipeline
  input  wire logic          decode_valid,
  input  wire op_class_type  decode_class,
  input  wire logic [7:0]    trap_vector,
  input  wire logic          insn_complete,
  input  wire logic [31:0]   core_pc,
  input  wire logic [31:0]   core_sp,
  input  wire logic [31:0]   core_sr,
  input  wire logic [31:0]   core_vbr,
  // Address error and interrupt sources
  input  wire logic          cpu_addr_err,
  input  wire logic          xfer_addr_err,
  input  wire logic          nmi_req,
  input  wire logic          break_req,
  input  wire logic          ext_int_req,
  input  wire logic [3:0]    ext_int_level,
  input  wire logic [7:0]    ext_int_vector,
  input  wire logic          periph_int_req,
  input  wire logic [3:0]    periph_int_level,
  input  wire logic [7:0]    periph_int_vector,
  output logic               int_ack,
  // Memory port
  output mem_req_type        mem_out,
  input  wire logic          mem_ack,
  input  wire logic [31:0]   mem_rdata,
  // Core register loads
  output core_load_type      core_load,
  output logic               core_hold
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          por_sync;
    logic [1:0]          mrst_sync;
    logic                por_prev;
    logic                mrst_prev;
    seq_state_type       state;
    logic                in_slot;
    logic                cpu_aerr_pend;
    logic                xfer_aerr_pend;
    logic                is_reset;
    logic                is_int;
    logic [7:0]          vec;
    logic [3:0]          level;
    logic [31:0]         pc_cap;
    logic [31:0]         sp_cap;
    logic [31:0]         sr_cap;
    logic [31:0]         vbr_cap;
    logic [31:0]         pc_fetched;
    logic [EVT_WIDTH-1:0] evt_status;
    logic [EVT_WIDTH-1:0] evt_mask;
    logic                irq;
    logic                int_ack;
    logic                hold;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    mem_req_type         mem;
    core_load_type       load;
  } seq_regs_type;

  seq_regs_type q;
  seq_regs_type d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_delayed(input op_class_type c);
    unique case (c)
      OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB, OP_RETURN, OP_EXC_RETURN,
      OP_DBR_FALSE, OP_DBR_TRUE, OP_FAR_BRANCH, OP_FAR_BRANCH_SUB: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_pc_modify(input op_class_type c);
    return is_delayed(c) || c == OP_BR_TRUE || c == OP_BR_FALSE || c == OP_TRAP;
  endfunction

  // Byte offset of a vector entry
  function automatic logic [31:0] vec_offset(input logic [7:0] v);
    return {22'h0, v, 2'b00};
  endfunction

  // Pin edges, read from second synchroniser stage only
  logic por_rise;
  logic mrst_rise;
  assign por_rise  = q.por_sync[1] && !q.por_prev;
  assign mrst_rise = q.mrst_sync[1] && !q.mrst_prev && q.por_sync[1];

  // Interrupt acceptance against the current mask
  logic [3:0] cur_mask;
  logic       ext_ok;
  logic       periph_ok;
  logic       any_async;
  assign cur_mask  = core_sr[MASK_LSB +: 4];
  assign ext_ok    = ext_int_req && (ext_int_level > cur_mask);
  assign periph_ok = periph_int_req && (periph_int_level > cur_mask);
  assign any_async = q.cpu_aerr_pend || xfer_addr_err || cpu_addr_err || q.xfer_aerr_pend
                     || nmi_req || (break_req && BREAK_LEVEL > cur_mask) || ext_ok
                     || periph_ok;

  // APB phase decode
  logic apb_access;
  logic apb_wr;
  logic [EVT_WIDTH-1:0] evt_set; // Events raised this cycle
  assign apb_access = psel && penable && q.pready;
  assign apb_wr     = apb_access && pwrite;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.load.pc_load  = 1'b0;
    d.load.sp_load  = 1'b0;
    d.load.sr_load  = 1'b0;
    d.load.vbr_load = 1'b0;
    d.int_ack       = 1'b0;
    evt_set         = '0;
    d.por_sync      = {q.por_sync[0], power_on_reset_pin};
    d.mrst_sync     = {q.mrst_sync[0], manual_reset_pin};
    d.por_prev      = q.por_sync[1];
    d.mrst_prev     = q.mrst_sync[1];
    // Address errors are pulses; hold them until taken
    d.cpu_aerr_pend  = q.cpu_aerr_pend || cpu_addr_err;
    d.xfer_aerr_pend = q.xfer_aerr_pend || xfer_addr_err;

    // Sequencer
    unique case (q.state)
      ST_IDLE: begin
        if (decode_valid) begin
          d.in_slot = is_delayed(decode_class);
          if (any_async) begin
            // Highest pending source wins; taken once current insn ends
            d.in_slot  = 1'b0;
            d.is_int   = 1'b0;
            d.level    = cur_mask;
            d.state    = ST_WAIT_DONE;
            if (q.cpu_aerr_pend || cpu_addr_err) begin
              d.vec           = VEC_CPU_AERR;
              d.cpu_aerr_pend = 1'b0;
            end else if (q.xfer_aerr_pend || xfer_addr_err) begin
              d.vec            = VEC_XFER_AERR;
              d.xfer_aerr_pend = 1'b0;
            end else if (nmi_req) begin
              d.vec    = VEC_NMI;
              d.is_int = 1'b1;
              d.level  = NMI_LEVEL;
            end else if (break_req && BREAK_LEVEL > cur_mask) begin
              d.vec    = VEC_USER_BREAK;
              d.is_int = 1'b1;
              d.level  = BREAK_LEVEL;
            end else if (ext_ok) begin
              d.vec    = ext_int_vector;
              d.is_int = 1'b1;
              d.level  = ext_int_level;
            end else begin
              d.vec    = periph_int_vector;
              d.is_int = 1'b1;
              d.level  = periph_int_level;
            end
            d.int_ack = d.is_int;
          end else if (q.in_slot && (decode_class == OP_UNDEFINED
                                     || is_pc_modify(decode_class))) begin
            d.vec   = VEC_SLOT_ILL;
            d.is_int = 1'b0;
            d.in_slot = 1'b0;
            d.state = ST_WAIT_DONE;
          end else if (decode_class == OP_UNDEFINED) begin
            d.vec   = VEC_ILLEGAL;
            d.is_int = 1'b0;
            d.state = ST_WAIT_DONE;
          end else if (decode_class == OP_TRAP) begin
            d.vec   = trap_vector;
            d.is_int = 1'b0;
            d.state = ST_WAIT_DONE;
          end
        end
      end
      ST_WAIT_DONE: begin
        // Snapshot the core once the instruction in flight has retired
        if (insn_complete) begin
          d.pc_cap  = core_pc;
          d.sp_cap  = core_sp - WORD_BYTES;
          d.sr_cap  = core_sr;
          d.vbr_cap = core_vbr;
          d.state   = ST_PUSH_SR;
          d.mem     = '{req: 1'b1, we: 1'b1, addr: core_sp - WORD_BYTES, wdata: core_sr};
        end
      end
      ST_PUSH_SR: begin
        if (mem_ack) begin
          d.sp_cap = q.sp_cap - WORD_BYTES;
          d.state  = ST_PUSH_PC;
          d.mem    = '{req: 1'b1, we: 1'b1, addr: q.sp_cap - WORD_BYTES, wdata: q.pc_cap};
        end
      end
      ST_PUSH_PC: begin
        if (mem_ack) begin
          d.state = ST_FETCH_VEC;
          d.mem   = '{req: 1'b1, we: 1'b0, addr: q.vbr_cap + vec_offset(q.vec), wdata: 32'h0};
        end
      end
      ST_FETCH_VEC: begin
        if (mem_ack) begin
          d.mem            = '0;
          d.state          = ST_IDLE;
          d.load.pc_load   = 1'b1;
          d.load.pc_value  = mem_rdata;
          d.load.sp_load   = 1'b1;
          d.load.sp_value  = q.sp_cap;
          d.load.sr_load   = 1'b1;
          d.load.sr_value  = q.sr_cap;
          if (q.is_int) begin
            d.load.sr_value[MASK_LSB +: 4] = q.level;
          end
          evt_set[q.is_int ? EVT_INT_BIT
                       : (q.vec == VEC_CPU_AERR || q.vec == VEC_XFER_AERR) ? EVT_AERR_BIT
                       : EVT_INSN_BIT] = 1'b1;
        end
      end
      ST_RST_PC: begin
        if (mem_ack) begin
          d.pc_fetched = mem_rdata;
          d.state      = ST_RST_SP;
          d.mem.addr   = vec_offset(q.vec + 8'h01);
        end
      end
      ST_RST_SP: begin
        if (mem_ack) begin
          d.mem            = '0;
          d.state          = ST_IDLE;
          d.load.pc_load   = 1'b1;
          d.load.pc_value  = q.pc_fetched;
          d.load.sp_load   = 1'b1;
          d.load.sp_value  = mem_rdata;
          d.load.vbr_load  = 1'b1;
          d.load.vbr_value = VBR_ON_RESET;
          d.load.sr_load   = 1'b1;
          d.load.sr_value  = core_sr;
          d.load.sr_value[MASK_LSB +: 4] = MASK_ON_RESET;
        end
      end
    endcase

    // Resets override any sequence in flight
    if (!q.por_sync[1]) begin
      d.state   = ST_IDLE;
      d.mem     = '0;
      d.in_slot = 1'b0;
    end else if (por_rise || mrst_rise) begin
      d.is_reset = 1'b1;
      d.is_int   = 1'b0;
      d.in_slot  = 1'b0;
      d.cpu_aerr_pend  = 1'b0;
      d.xfer_aerr_pend = 1'b0;
      d.vec      = por_rise ? VEC_POR_PC : VEC_MRST_PC;
      d.state    = ST_RST_PC;
      d.mem      = '{req: 1'b1, we: 1'b0, addr: vec_offset(d.vec), wdata: 32'h0};
      evt_set[por_rise ? EVT_POR_BIT : EVT_MRST_BIT] = 1'b1;
    end else if (q.state == ST_WAIT_DONE && insn_complete) begin
      d.is_reset = 1'b0;
    end

    // APB: read data and error registered in setup so they stand with pready;
    // writes land in the access cycle, and a hardware set wins over a clear
    d.pready     = psel && !penable;
    d.pslverr    = 1'b0;
    d.prdata     = 32'h0;
    d.evt_status = q.evt_status | evt_set;
    unique case (paddr)
      EVT_STATUS_OFFSET: begin
        if (d.pready) d.prdata[EVT_WIDTH-1:0] = q.evt_status;
        if (apb_wr) d.evt_status = (q.evt_status & ~pwdata[EVT_WIDTH-1:0]) | evt_set;
      end
      EVT_MASK_OFFSET: begin
        if (d.pready) d.prdata[EVT_WIDTH-1:0] = q.evt_mask;
        if (apb_wr) d.evt_mask = pwdata[EVT_WIDTH-1:0];
      end
      LAST_EXC_OFFSET: if (d.pready) d.prdata = {19'h0, q.is_int, q.level, q.vec};
      default: d.pslverr = d.pready;
    endcase

    // Level interrupt from masked sticky events
    d.irq  = |(d.evt_status & d.evt_mask);
    d.hold = (d.state != ST_IDLE) || !q.por_sync[1];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.state    <= ST_IDLE;
      q.evt_mask <= EVT_MASK_RESET;
      q.hold     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign irq       = q.irq;
  assign int_ack   = q.int_ack;
  assign mem_out   = q.mem;
  assign core_load = q.load;
  assign core_hold = q.hold;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_por_entry: assert property (por_rise |=> q.state == ST_RST_PC && q.vec == VEC_POR_PC)
    else $error("power-on reset entry not started");
  a_mrst_entry: assert property (mrst_rise && !por_rise |=> q.vec == VEC_MRST_PC)
    else $error("manual reset entry not started");
  a_reset_fetch: assert property (q.state == ST_RST_PC && q.mem.req
      |-> !q.mem.we && q.mem.addr == vec_offset(q.vec))
    else $error("reset PC fetch address wrong");
  a_reset_init: assert property (q.load.vbr_load |-> q.load.vbr_value == VBR_ON_RESET
      && q.load.sr_value[MASK_LSB +: 4] == MASK_ON_RESET && q.load.pc_load)
    else $error("reset did not clear base or set mask");
  a_wait_retire: assert property (q.state == ST_WAIT_DONE && !insn_complete && q.por_sync[1]
      && !por_rise && !mrst_rise |=> q.state == ST_WAIT_DONE)
    else $error("exception started before instruction completed");
  a_push_order: assert property (q.state == ST_PUSH_SR && q.mem.req |-> q.mem.we
      && q.mem.wdata == q.sr_cap && q.mem.addr == q.sp_cap)
    else $error("status word push wrong");
  a_vector_addr: assert property (q.state == ST_FETCH_VEC && q.mem.req
      |-> q.mem.addr == q.vbr_cap + vec_offset(q.vec))
    else $error("vector fetch address wrong");
  a_int_mask: assert property (q.state == ST_FETCH_VEC && mem_ack && q.por_sync[1] && !por_rise
      && !mrst_rise |=> q.load.sr_value[MASK_LSB +: 4]
      == (q.is_int ? $past(q.level) : $past(q.sr_cap[MASK_LSB +: 4])))
    else $error("interrupt mask update wrong");
  a_slot_illegal: assert property (q.state == ST_IDLE && decode_valid && q.in_slot && !any_async
      && decode_class == OP_TRAP && q.por_sync[1] && !por_rise && !mrst_rise
      |=> q.vec == VEC_SLOT_ILL)
    else $error("slot illegal not raised");
  a_irq_level: assert property (##1 irq == |(q.evt_status & q.evt_mask))
    else $error("interrupt output mismatch");

  c_por_done: cover property (q.state == ST_RST_SP && mem_ack);
  c_int_taken: cover property (q.state == ST_FETCH_VEC && mem_ack && q.is_int);
  c_slot_taken: cover property (q.state == ST_FETCH_VEC && mem_ack && q.vec == VEC_SLOT_ILL);

endmodule // cpu_exception_sequencer

/* File: bench/mem_model.sv */
// Memory port partner for the exception sequencer: answers reads and writes.
// Assumes requests are held until acknowledged and completed on req && ack.
`timescale 1ns/1ns
module mem_model
  import exc_seq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire mem_req_type mem_out,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [1:0] wait_q;

  // -------------------------------------------------------------
  // Answer logic
  // -------------------------------------------------------------
  // Read data is address-derived so every fetch is distinguishable;
  // between answers the data bus toggles so stale values never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 32'hFFFF_FFFF;
    end else if (mem_ack || !mem_out.req) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (!slow || wait_q == 2'h3) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_out.addr ^ 32'h5A5A_0000;
    end else begin
      wait_q    <= wait_q + 2'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_model

/* File: bench/cpu_exception_sequencer_tb.sv */
// Self-checking bench for the exception sequencer, one task per scenario.
// Assumes mem_model answers with data = address ^ 5A5A0000.
`timescale 1ns/1ns
module cpu_exception_sequencer_tb
  import exc_seq_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn, psel, penable, pwrite, power_on_reset_pin, manual_reset_pin;
  logic          decode_valid, insn_complete, cpu_addr_err, xfer_addr_err, nmi_req;
  logic          break_req, ext_int_req, periph_int_req, mem_ack, slow;
  logic          pready, pslverr, irq, int_ack, core_hold;
  logic [7:0]    paddr, trap_vector, ext_int_vector, periph_int_vector;
  logic [3:0]    ext_int_level, periph_int_level;
  logic [31:0]   pwdata, prdata, core_pc, core_sp, core_sr, core_vbr, mem_rdata;
  op_class_type  decode_class;
  mem_req_type   mem_out;
  core_load_type core_load;
  int            n_mismatch, check_count, n_ack;
  logic [64:0]   log_q[$];

  cpu_exception_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .power_on_reset_pin, .manual_reset_pin,
    .decode_valid, .decode_class, .trap_vector, .insn_complete, .core_pc, .core_sp,
    .core_sr, .core_vbr, .cpu_addr_err, .xfer_addr_err, .nmi_req, .break_req,
    .ext_int_req, .ext_int_level, .ext_int_vector, .periph_int_req, .periph_int_level,
    .periph_int_vector, .int_ack, .mem_out, .mem_ack, .mem_rdata, .core_load, .core_hold);

  mem_model mem_u (.pclk, .presetn, .mem_out, .slow, .mem_ack, .mem_rdata);

  // -------------------------------------------------------------
  // Clock, access log, helpers
  // -------------------------------------------------------------
  always #5 pclk = ~pclk;

  // Completed memory accesses as {we, addr, wdata}
  always @(posedge pclk) if (mem_out.req && mem_ack) log_q.push_back({mem_out.we, mem_out.addr, mem_out.wdata});

  // Interrupt acknowledge pulses seen
  always @(posedge pclk) if (int_ack === 1'b1) n_ack++;

  task automatic chk(input string nm, input logic [64:0] seen, input logic [64:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for the register load pulse, sampled mid-cycle
  task automatic wait_load();
    int n;
    n = 0;
    while (core_load.pc_load !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk("load", core_load.pc_load, 1);
  endtask

  // APB transfer: request held until pready is high at a rising edge, data
  // and error taken at that edge; one idle edge follows before the next
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) n_mismatch++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Reset entry through a pin rising edge; base 0 or 8
  task automatic rst_entry(input logic man);
    logic [31:0] b;
    b = man ? 32'h0000_0008 : 32'h0000_0000;
    log_q.delete();
    if (man) manual_reset_pin <= 1'b0;
    else power_on_reset_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    manual_reset_pin   <= 1'b1;
    power_on_reset_pin <= 1'b1;
    wait_load();
    chk("pc", core_load.pc_value, b ^ 32'h5A5A_0000);
    chk("sp", core_load.sp_value, (b + 4) ^ 32'h5A5A_0000);
    chk("vbr", {core_load.vbr_load, core_load.vbr_value}, 33'h1_0000_0000);
    chk("mask", core_load.sr_value[7:4], 4'hF);
    chk("loads", {core_load.sp_load, core_load.sr_load}, 2'b11);
    chk("reads", log_q.size(), 2);
    @(posedge pclk);
    $display("reset entry %0d done", man);
  endtask

  // Decode pre then cls with sources; sp 1000, pc 400, sr mask 3, base 2000
  task automatic exc(input op_class_type pre, cls, input logic [2:0] src,
                     input logic [7:0] tv, vec, input logic [3:0] msk);
    logic [31:0] va;
    int          a0;
    va = 32'h0000_2000 + {22'h0, vec, 2'b00};
    a0 = n_ack;
    log_q.delete();
    slow         <= ~slow;
    decode_valid <= 1'b1;
    decode_class <= pre;
    @(posedge pclk);
    decode_class <= cls;
    trap_vector  <= tv;
    {ext_int_req, nmi_req, cpu_addr_err} <= src;
    @(posedge pclk);
    decode_valid <= 1'b0;
    {ext_int_req, nmi_req, cpu_addr_err} <= 3'h0;
    repeat (3) @(posedge pclk);
    chk("early", log_q.size(), 0);
    chk("busy", core_hold, 1);
    insn_complete <= 1'b1;
    @(posedge pclk);
    insn_complete <= 1'b0;
    wait_load();
    chk("free", core_hold, 0);
    chk("int_ack", n_ack - a0, (src[1] || src[2]) && !src[0]);
    chk("accesses", log_q.size(), 3);
    if (log_q.size() == 3) begin
      chk("push_sr", log_q[0], {1'b1, 32'h0000_0FFC, 32'h0000_0030});
      chk("push_pc", log_q[1], {1'b1, 32'h0000_0FF8, 32'h0000_0400});
      chk("vec_rd", log_q[2][64:32], {1'b0, va});
    end
    chk("new_pc", core_load.pc_value, va ^ 32'h5A5A_0000);
    chk("new_sp", core_load.sp_value, 32'h0000_0FF8);
    chk("mask", core_load.sr_value[7:4], msk);
    @(posedge pclk);
    $display("exception vector %h done", vec);
  endtask

  // Status, mask, interrupt line and an unmapped offset
  task automatic reg_test();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("mask_rst", q, 32'h0);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("status", q[4:0], 5'h1F);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("last_vec", q[7:0], 8'h06);
    apb(1'b1, 8'h04, 32'h8, q, e);
    @(negedge pclk);
    chk("irq_on", irq, 1);
    @(posedge pclk);
    apb(1'b1, 8'h00, 32'h8, q, e);
    @(negedge pclk);
    chk("irq_off", irq, 0);
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("w1c", q[4:0], 5'h17);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("unmapped", {e, q}, 33'h1_0000_0000);
    $display("registers done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, power_on_reset_pin, decode_valid, insn_complete} = '0;
    {cpu_addr_err, xfer_addr_err, nmi_req, break_req, ext_int_req, periph_int_req} = '0;
    {slow, paddr, pwdata, trap_vector, periph_int_vector, periph_int_level} = '0;
    manual_reset_pin = 1'b1;
    decode_class = OP_OTHER;
    ext_int_level = 4'h5;
    ext_int_vector = 8'h40;
    core_pc = 32'h0000_0400;
    core_sp = 32'h0000_1000;
    core_sr = 32'h0000_0030;
    core_vbr = 32'h0000_2000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rst_entry(1'b0);
    rst_entry(1'b1);
    exc(OP_OTHER, OP_OTHER, 3'b010, 8'h00, 8'h0B, 4'hF);
    exc(OP_OTHER, OP_OTHER, 3'b100, 8'h00, 8'h40, 4'h5);
    exc(OP_OTHER, OP_UNDEFINED, 3'b011, 8'h00, 8'h09, 4'h3);
    exc(OP_OTHER, OP_UNDEFINED, 3'b000, 8'h00, 8'h04, 4'h3);
    exc(OP_OTHER, OP_TRAP, 3'b000, 8'h20, 8'h20, 4'h3);
    exc(OP_FAR_BRANCH, OP_BR_TRUE, 3'b000, 8'h00, 8'h06, 4'h3);
    exc(OP_JUMP, OP_UNDEFINED, 3'b000, 8'h00, 8'h06, 4'h3);
    reg_test();
    print_verdict();
  end

  // Whole run is a few hundred cycles; a hang is cut far beyond that
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule // cpu_exception_sequencer_tb
